// *** common/sens_hib_consts.svh ***
`ifndef SENS_HIB_CONSTS_SVH
`define SENS_HIB_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define CFG_ADDR          8'h19
`define CFG_RESET         8'h00
`define CFG_USED_MASK     8'h1F
`define CFG_MAG_EN_BIT    4
`define CFG_X_SKIP_BIT    3
`define CFG_Y_SKIP_BIT    2
`define CFG_Z_SKIP_BIT    1
`define CFG_HIB_BIT       0
`define READ_ZERO         8'h00

// ****************************************
// Change detector source codes
// ****************************************
`define SRC_SEL_MAGNITUDE 2'h1

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ      25
`define BOOT1_TIME_US     1000
`define BOOT2_TIME_US     1000
`define BOOT_CNT_ZERO     24'h00_0000

// ****************************************
// Magnitude calculation
// ****************************************
`define SQ_SUM_ZERO       26'h000_0000
`define SQRT_ONE_INIT     26'h100_0000
`define SQRT_LAST_ONE     26'h000_0001
`define MAG_ZERO          12'h000

`endif

// *** common/sens_hib_pkg.sv ***
package sens_hib_pkg;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_HIBERNATE,
      ST_BOOT
   } power_state_t;

   typedef logic [7:0]  reg_byte_t;
   typedef logic [11:0] mag_word_t;

endpackage

// *** hdl/vector_magnitude_calc.sv ***
`timescale 1ns/10ps
`include "sens_hib_consts.svh"

module vector_magnitude_calc (
   input  wire logic                    mclk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    start_i,
   input  wire logic signed [11:0]      x_i,
   input  wire logic signed [11:0]      y_i,
   input  wire logic signed [11:0]      z_i,
   output logic                         done_o,
   output logic [11:0]                  mag_o
);
   import sens_hib_pkg::*;

   // ****************************************
   // Sum of squares
   // ****************************************
   wire logic signed [23:0] x_sq  = x_i * x_i;
   wire logic signed [23:0] y_sq  = y_i * y_i;
   wire logic signed [23:0] z_sq  = z_i * z_i;
   wire logic        [25:0] sq_sum = 26'(unsigned'(x_sq)) + 26'(unsigned'(y_sq))
                                     + 26'(unsigned'(z_sq));

   // ****************************************
   // Bitwise square root, one bit per cycle
   // ****************************************
   logic [25:0] op_reg;
   logic [25:0] res_reg;
   logic [25:0] one_reg;
   logic        busy_reg;

   wire logic [25:0] trial    = res_reg + one_reg;
   wire logic        take_bit = op_reg >= trial;
   wire logic        last_bit = one_reg == `SQRT_LAST_ONE;
   wire logic [25:0] res_next = take_bit ? ((res_reg >> 1) + one_reg) : (res_reg >> 1);

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         op_reg   <= `SQ_SUM_ZERO;
         res_reg  <= `SQ_SUM_ZERO;
         one_reg  <= `SQ_SUM_ZERO;
         busy_reg <= 1'b0;
         done_o   <= 1'b0;
         mag_o    <= `MAG_ZERO;
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_reg) begin
            op_reg   <= sq_sum;
            res_reg  <= `SQ_SUM_ZERO;
            one_reg  <= `SQRT_ONE_INIT;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (take_bit) begin
               op_reg <= op_reg - trial;
            end
            res_reg <= res_next;
            one_reg <= one_reg >> 2;
            if (last_bit) begin
               busy_reg <= 1'b0;
               done_o   <= 1'b1;
               mag_o    <= res_next[11:0];
            end
         end
      end
   end

endmodule

// *** hdl/sens_hibernate_ctrl.sv ***
`timescale 1ns/10ps
`include "sens_hib_consts.svh"

module sens_hibernate_ctrl #(
   parameter int unsigned BOOT1_TIME_US = `BOOT1_TIME_US,
   parameter int unsigned BOOT2_TIME_US = `BOOT2_TIME_US
) (
   input  wire logic                    mclk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   input  wire logic [7:0]              reg_addr_i,
   input  wire sens_hib_pkg::reg_byte_t reg_wdata_i,
   input  wire logic                    boot_strap_select_i,
   input  wire logic                    wake_pin_i,
   input  wire logic                    motion_pin_i,
   input  wire logic                    odr_tick_i,
   input  wire logic                    sleep_state_i,
   input  wire logic [1:0]              wake_power_mode_field_i,
   input  wire logic [1:0]              sleep_power_mode_field_i,
   input  wire logic [1:0]              change_detector_source_select_i,
   input  wire logic signed [11:0]      x_data_i,
   input  wire logic signed [11:0]      y_data_i,
   input  wire logic signed [11:0]      z_data_i,
   output sens_hib_pkg::reg_byte_t      reg_rdata_o,
   output sens_hib_pkg::mag_word_t      magnitude_result_o,
   output logic                         magnitude_valid_o,
   output sens_hib_pkg::mag_word_t      change_detector_data_o,
   output logic                         change_detector_valid_o,
   output logic                         x_in_burst_o,
   output logic                         y_in_burst_o,
   output logic                         z_in_burst_o,
   output logic                         magnitude_in_burst_o,
   output logic [1:0]                   power_mode_o,
   output logic                         hibernate_o,
   output logic                         volatile_clear_o,
   output logic                         booting_o,
   output logic                         motion_active_o
);
   import sens_hib_pkg::*;

   // ****************************************
   // Boot wait counts
   // ****************************************
   localparam int unsigned BOOT1_CYCLES = BOOT1_TIME_US * `CLK_FREQ_MHZ;
   localparam int unsigned BOOT2_CYCLES = BOOT2_TIME_US * `CLK_FREQ_MHZ;
   localparam logic [23:0] BOOT1_LAST   = 24'(BOOT1_CYCLES - 1);
   localparam logic [23:0] BOOT2_LAST   = 24'(BOOT2_CYCLES - 1);

   // ****************************************
   // State
   // ****************************************
   power_state_t state_reg;
   power_state_t state_next;
   reg_byte_t    cfg_reg;
   reg_byte_t    cfg_next;
   logic         strap_vdd_reg;
   logic         strap_taken_reg;
   logic         wake_level_reg;
   logic [23:0]  boot_cnt_reg;
   logic [23:0]  boot_cnt_next;
   logic         boot_long_reg;
   logic         boot_long_next;
   logic         mag_done;
   mag_word_t    mag_value;

   // ****************************************
   // Decoding
   // ****************************************
   wire logic cfg_hit     = reg_addr_i == `CFG_ADDR;
   wire logic running     = state_reg == ST_RUN;
   wire logic cfg_write   = reg_wr_i && cfg_hit && running;
   wire logic mag_en      = cfg_reg[`CFG_MAG_EN_BIT];
   wire logic hib_request = cfg_write && reg_wdata_i[`CFG_HIB_BIT] && !strap_vdd_reg;
   wire logic wake_edge   = wake_pin_i != wake_level_reg;
   wire logic motion_low  = strap_vdd_reg && !motion_pin_i;
   wire logic motion_high = strap_vdd_reg && motion_pin_i;
   wire logic boot_last   = boot_cnt_reg == (boot_long_reg ? BOOT2_LAST : BOOT1_LAST);
   wire logic enter_hib   = strap_taken_reg && (hib_request || (running && motion_low));
   wire logic mag_start   = running && mag_en && odr_tick_i;
   wire logic cd_use_mag  = change_detector_source_select_i == `SRC_SEL_MAGNITUDE;
   wire logic [1:0] mode_sel = sleep_state_i ? sleep_power_mode_field_i
                                             : wake_power_mode_field_i;

   // ****************************************
   // Configuration register
   // ****************************************
   always_comb begin
      cfg_next = cfg_reg;
      if (enter_hib) begin
         cfg_next = `CFG_RESET;
      end else if (cfg_write) begin
         cfg_next = reg_wdata_i & `CFG_USED_MASK;
         if (strap_vdd_reg) begin
            cfg_next[`CFG_HIB_BIT] = 1'b0;
         end
      end
   end

   // ****************************************
   // Power state machine
   // ****************************************
   always_comb begin
      state_next     = state_reg;
      boot_cnt_next  = boot_cnt_reg;
      boot_long_next = boot_long_reg;
      case (state_reg)
         ST_RUN: begin
            if (enter_hib) begin
               state_next = ST_HIBERNATE;
            end
         end
         ST_HIBERNATE: begin
            if (strap_vdd_reg) begin
               if (motion_high) begin
                  state_next     = ST_BOOT;
                  boot_cnt_next  = `BOOT_CNT_ZERO;
                  boot_long_next = 1'b1;
               end
            end else if (wake_edge) begin
               state_next     = ST_BOOT;
               boot_cnt_next  = `BOOT_CNT_ZERO;
               boot_long_next = 1'b0;
            end
         end
         ST_BOOT: begin
            if (motion_low) begin
               state_next = ST_HIBERNATE;
            end else if (boot_last) begin
               state_next = ST_RUN;
            end else begin
               boot_cnt_next = boot_cnt_reg + 24'h00_0001;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // ****************************************
   // Strap capture after reset release
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_vdd_reg   <= 1'b0;
         strap_taken_reg <= 1'b0;
      end else if (!strap_taken_reg) begin
         strap_vdd_reg   <= boot_strap_select_i;
         strap_taken_reg <= 1'b1;
      end
   end

   // ****************************************
   // Core state registers
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg      <= ST_RUN;
         cfg_reg        <= `CFG_RESET;
         boot_cnt_reg   <= `BOOT_CNT_ZERO;
         boot_long_reg  <= 1'b0;
         wake_level_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cfg_reg       <= cfg_next;
         boot_cnt_reg  <= boot_cnt_next;
         boot_long_reg <= boot_long_next;
         if (running) begin
            wake_level_reg <= wake_pin_i;
         end
      end
   end

   // ****************************************
   // Vector magnitude
   // ****************************************
   vector_magnitude_calc u_magnitude (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .start_i (mag_start),
      .x_i     (x_data_i),
      .y_i     (y_data_i),
      .z_i     (z_data_i),
      .done_o  (mag_done),
      .mag_o   (mag_value)
   );

   wire logic mag_accept = mag_done && running && mag_en;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         magnitude_result_o      <= `MAG_ZERO;
         magnitude_valid_o       <= 1'b0;
         change_detector_data_o  <= `MAG_ZERO;
         change_detector_valid_o <= 1'b0;
      end else begin
         magnitude_valid_o       <= mag_accept;
         change_detector_valid_o <= mag_accept && cd_use_mag;
         if (enter_hib) begin
            magnitude_result_o     <= `MAG_ZERO;
            change_detector_data_o <= `MAG_ZERO;
         end else if (mag_accept) begin
            magnitude_result_o <= mag_value;
            if (cd_use_mag) begin
               change_detector_data_o <= mag_value;
            end
         end
      end
   end

   // ****************************************
   // Burst range and mode outputs
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         x_in_burst_o         <= 1'b1;
         y_in_burst_o         <= 1'b1;
         z_in_burst_o         <= 1'b1;
         magnitude_in_burst_o <= 1'b0;
         power_mode_o         <= 2'h0;
         hibernate_o          <= 1'b0;
         volatile_clear_o     <= 1'b0;
         booting_o            <= 1'b0;
         motion_active_o      <= 1'b0;
      end else begin
         x_in_burst_o         <= !cfg_next[`CFG_X_SKIP_BIT];
         y_in_burst_o         <= !cfg_next[`CFG_Y_SKIP_BIT];
         z_in_burst_o         <= !cfg_next[`CFG_Z_SKIP_BIT];
         magnitude_in_burst_o <= cfg_next[`CFG_MAG_EN_BIT];
         power_mode_o         <= mode_sel;
         hibernate_o          <= state_next == ST_HIBERNATE;
         volatile_clear_o     <= enter_hib;
         booting_o            <= state_next == ST_BOOT;
         motion_active_o      <= strap_vdd_reg && state_next == ST_RUN;
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= `READ_ZERO;
      end else if (reg_rd_i && cfg_hit && running) begin
         reg_rdata_o <= cfg_reg & `CFG_USED_MASK;
      end else begin
         reg_rdata_o <= `READ_ZERO;
      end
   end

endmodule

// *** verif/sens_hibernate_ctrl_checker.sv ***
`timescale 1ns/10ps
`include "sens_hib_consts.svh"
module cfg_hib_checker #(
   parameter int unsigned BOOT1_TIME_US = 1,
   parameter int unsigned BOOT2_TIME_US = 1
) (
   input wire logic                    mclk_i,
   input wire logic                    rstn_i,
   input wire logic                    reg_wr_i,
   input wire logic                    reg_rd_i,
   input wire logic [7:0]              reg_addr_i,
   input wire sens_hib_pkg::reg_byte_t reg_wdata_i,
   input wire logic                    boot_strap_select_i,
   input wire logic                    wake_pin_i,
   input wire logic                    motion_pin_i,
   input wire sens_hib_pkg::reg_byte_t reg_rdata_o,
   input wire logic                    x_in_burst_o,
   input wire logic                    y_in_burst_o,
   input wire logic                    z_in_burst_o,
   input wire logic                    magnitude_in_burst_o,
   input wire logic                    hibernate_o,
   input wire logic                    volatile_clear_o,
   input wire logic                    booting_o
);
   import sens_hib_pkg::*;
   localparam int unsigned B1C = BOOT1_TIME_US * `CLK_FREQ_MHZ;
   localparam int unsigned B2C = BOOT2_TIME_US * `CLK_FREQ_MHZ;
   logic [23:0] boot_cnt;
   logic [3:0]  wfield;
   logic        served;
   assign wfield = reg_wdata_i[4:1];
   assign served = reg_addr_i == `CFG_ADDR && !hibernate_o && !booting_o;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) boot_cnt <= `BOOT_CNT_ZERO;
      else boot_cnt <= booting_o ? boot_cnt + 24'h00_0001 : `BOOT_CNT_ZERO;
   end
   // ****************
   // Properties
   // ****************
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   rdata_idle_a: assert property (!(reg_rd_i && served) |=> reg_rdata_o == `READ_ZERO)
      else $error("read data not idle");
   rsvd_zero_a: assert property (reg_rd_i |=> reg_rdata_o[7:5] == 3'h0)
      else $error("reserved bits not zero");
   cfg_fields_a: assert property (
      reg_wr_i && served && !reg_wdata_i[`CFG_HIB_BIT] |=>
      {magnitude_in_burst_o, ~x_in_burst_o, ~y_in_burst_o, ~z_in_burst_o} == $past(wfield))
      else $error("burst range flags wrong");
   hib_entry_a: assert property (
      reg_wr_i && served && reg_wdata_i[`CFG_HIB_BIT] && !boot_strap_select_i |=>
      hibernate_o && volatile_clear_o && !magnitude_in_burst_o)
      else $error("hibernate entry wrong");
   clear_pulse_a: assert property (volatile_clear_o |=> !volatile_clear_o && hibernate_o)
      else $error("clear pulse wrong");
   wake_exit_a: assert property (
      hibernate_o && !boot_strap_select_i && $changed(wake_pin_i) |=> booting_o && !hibernate_o)
      else $error("wake edge ignored");
   boot_len_a: assert property (
      $fell(booting_o) && !hibernate_o |-> boot_cnt - (boot_strap_select_i ? B2C : B1C) <= 1)
      else $error("boot time wrong");
   supply_sleep_a: assert property (
      boot_strap_select_i && !motion_pin_i && !hibernate_o && $past(rstn_i) |=> hibernate_o)
      else $error("motion low did not hibernate");
   motion_boot_a: assert property (
      boot_strap_select_i && motion_pin_i && hibernate_o |=> booting_o && !hibernate_o)
      else $error("motion high did not boot");
endmodule

bind sens_hibernate_ctrl cfg_hib_checker #(
   .BOOT1_TIME_US(BOOT1_TIME_US), .BOOT2_TIME_US(BOOT2_TIME_US)) chk (.*);

// *** verif/cfg_host_model.sv ***
`timescale 1ns/10ps
module cfg_host_model #(
   parameter int BOOT_CYCLES = 25
) (
   input  wire logic       mclk_i,
   input  wire logic [7:0] rdata_i,
   output logic            wr_o = 1'b0,
   output logic            rd_o = 1'b0,
   output logic [7:0]      addr_o = 8'h00,
   output logic [7:0]      wdata_o = 8'h00,
   output logic            wake_o = 1'b1,
   output logic            motion_o = 1'b0
);
   // ****************
   // Host accesses
   // ****************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge mclk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge mclk_i);
      rd_o = 1'b0;
      d = rdata_i;
   endtask
   task automatic wake_toggle();
      @(negedge mclk_i);
      wake_o = ~wake_o;
   endtask
   task automatic boot_wait();
      repeat (BOOT_CYCLES + 4) @(negedge mclk_i);
   endtask
   task automatic set_motion(input logic v);
      @(negedge mclk_i);
      motion_o = v;
      if (v) boot_wait();
   endtask
endmodule

// *** verif/sensor_output_and_hibernate_config_test.sv ***
`timescale 1ns/10ps
`include "sens_hib_consts.svh"
module sensor_output_and_hibernate_config_test;
   import sens_hib_pkg::*;
   logic               mclk_i = 1'b0, rstn_i = 1'b0, boot_strap_select_i = 1'b0;
   logic               odr_tick_i = 1'b0, sleep_state_i = 1'b0;
   logic [1:0]         wake_power_mode_field_i = 2'h0, sleep_power_mode_field_i = 2'h0;
   logic [1:0]         change_detector_source_select_i = 2'h0, power_mode_o;
   logic signed [11:0] x_data_i = 12'h000, y_data_i = 12'h000, z_data_i = 12'h000;
   logic               reg_wr_i, reg_rd_i, wake_pin_i, motion_pin_i;
   logic [7:0]         reg_addr_i;
   reg_byte_t          reg_wdata_i, reg_rdata_o, rd_val;
   mag_word_t          magnitude_result_o, change_detector_data_o;
   logic               magnitude_valid_o, change_detector_valid_o, hibernate_o, booting_o;
   logic               x_in_burst_o, y_in_burst_o, z_in_burst_o, magnitude_in_burst_o;
   logic               volatile_clear_o, motion_active_o;
   int                 mismatches = 0, num_checks = 0, cycles = 0;

   sens_hibernate_ctrl #(.BOOT1_TIME_US(1), .BOOT2_TIME_US(1)) uut (.*);
   cfg_host_model #(.BOOT_CYCLES(25)) host (
      .mclk_i(mclk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
      .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wake_o(wake_pin_i), .motion_o(motion_pin_i));

   initial forever #20 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         finish_test();
      end
   end
   // ****************
   // Scenarios
   // ****************
   task automatic chk_v(input string n, input mag_word_t e, input mag_word_t g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_f(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic do_reset(input logic s);
      @(negedge mclk_i);
      rstn_i = 1'b0;
      boot_strap_select_i = s;
      repeat (12) @(negedge mclk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge mclk_i);
   endtask
   task automatic t_fields();
      reg_byte_t pat [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'hE0};
      host.rd(`CFG_ADDR, rd_val);
      chk_v("reset value", {4'h0, `CFG_RESET}, {4'h0, rd_val});
      chk_f("mag burst", 1'b0, magnitude_in_burst_o);
      foreach (pat[i]) begin
         host.wr(`CFG_ADDR, pat[i]);
         host.rd(`CFG_ADDR, rd_val);
         chk_v("config", {4'h0, pat[i] & `CFG_USED_MASK}, {4'h0, rd_val});
         chk_f("mag burst", pat[i][4], magnitude_in_burst_o);
         chk_f("x burst", ~pat[i][3], x_in_burst_o);
         chk_f("y burst", ~pat[i][2], y_in_burst_o);
         chk_f("z burst", ~pat[i][1], z_in_burst_o);
      end
      host.wr(8'h1A, 8'h1E);
      host.rd(8'h1A, rd_val);
      chk_v("unmapped", {4'h0, `READ_ZERO}, {4'h0, rd_val});
      $display("test fields done");
   endtask
   task automatic t_mag();
      logic seen;
      logic got;
      change_detector_source_select_i = `SRC_SEL_MAGNITUDE;
      x_data_i = 12'h003;
      y_data_i = 12'hFFC;
      z_data_i = 12'h00C;
      host.wr(`CFG_ADDR, 8'h10);
      @(negedge mclk_i) odr_tick_i = 1'b1;
      @(negedge mclk_i) odr_tick_i = 1'b0;
      for (int k = 0; k < 40 && magnitude_valid_o !== 1'b1; k++) @(negedge mclk_i);
      chk_f("mag valid", 1'b1, magnitude_valid_o);
      chk_v("magnitude", 12'h00D, magnitude_result_o);
      for (int k = 0; k < 3 && change_detector_valid_o !== 1'b1; k++) @(negedge mclk_i);
      chk_f("detector valid", 1'b1, change_detector_valid_o);
      chk_v("detector data", 12'h00D, change_detector_data_o);
      change_detector_source_select_i = 2'h2;
      @(negedge mclk_i) odr_tick_i = 1'b1;
      @(negedge mclk_i) odr_tick_i = 1'b0;
      seen = 1'b0;
      got = 1'b0;
      repeat (20) @(negedge mclk_i) begin
         seen = seen | change_detector_valid_o;
         got = got | magnitude_valid_o;
      end
      chk_f("mag valid again", 1'b1, got);
      chk_f("detector unselected", 1'b0, seen);
      host.wr(`CFG_ADDR, 8'h00);
      @(negedge mclk_i) odr_tick_i = 1'b1;
      @(negedge mclk_i) odr_tick_i = 1'b0;
      seen = 1'b0;
      repeat (30) @(negedge mclk_i) seen = seen | magnitude_valid_o;
      chk_f("mag pulse when off", 1'b0, seen);
      $display("test magnitude done");
   endtask
   task automatic t_power();
      for (int m = 0; m < 4; m++) begin
         wake_power_mode_field_i = m[1:0];
         sleep_power_mode_field_i = ~m[1:0];
         sleep_state_i = m[0];
         repeat (2) @(negedge mclk_i);
         chk_v("power mode", {10'h000, m[0] ? ~m[1:0] : m[1:0]}, {10'h000, power_mode_o});
      end
      $display("test power done");
   endtask
   task automatic t_hib();
      host.wr(`CFG_ADDR, 8'h1F);
      chk_f("hibernate", 1'b1, hibernate_o);
      chk_f("volatile clear", 1'b1, volatile_clear_o);
      chk_v("magnitude", 12'h000, magnitude_result_o);
      host.rd(`CFG_ADDR, rd_val);
      chk_v("read asleep", {4'h0, `READ_ZERO}, {4'h0, rd_val});
      host.wake_toggle();
      @(negedge mclk_i);
      chk_f("booting", 1'b1, booting_o);
      host.boot_wait();
      chk_f("boot done", 1'b0, booting_o);
      host.rd(`CFG_ADDR, rd_val);
      chk_v("config wiped", {4'h0, `CFG_RESET}, {4'h0, rd_val});
      chk_f("x burst", 1'b1, x_in_burst_o);
      $display("test hibernate done");
   endtask
   task automatic t_supply();
      do_reset(1'b1);
      chk_f("hibernate", 1'b1, hibernate_o);
      host.set_motion(1'b1);
      chk_f("motion active", 1'b1, motion_active_o);
      chk_f("hibernate", 1'b0, hibernate_o);
      host.wr(`CFG_ADDR, 8'h01);
      host.rd(`CFG_ADDR, rd_val);
      chk_v("strap bit", {4'h0, `READ_ZERO}, {4'h0, rd_val});
      host.set_motion(1'b0);
      @(negedge mclk_i);
      chk_f("hibernate", 1'b1, hibernate_o);
      @(negedge mclk_i) host.motion_o = 1'b1;
      repeat (5) @(negedge mclk_i);
      chk_f("booting", 1'b1, booting_o);
      host.set_motion(1'b0);
      @(negedge mclk_i);
      chk_f("boot cut", 1'b1, hibernate_o);
      chk_f("boot cut booting", 1'b0, booting_o);
      $display("test supply strap done");
   endtask

   initial begin
      do_reset(1'b0);
      t_fields();
      t_mag();
      t_power();
      t_hib();
      t_supply();
      finish_test();
   end
endmodule
